/* bench/epb_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module epb_partner (
  input wire logic i_core_clk,
  input wire logic i_go_req,
  input wire logic i_go_rel,
  input wire logic i_hold_ack,
  output epb_pkg::epb_hs_s o_cable_hs,
  output logic [15:0] o_cable_ad
);
  // ----------------------------------------
  // coprocessor pulses, three clocks wide
  // ----------------------------------------
  logic [1:0] req_cnt = 2'h0;
  logic [1:0] rel_cnt = 2'h0;
  logic [15:0] rd_ff = 16'h5a3c;
  always @(posedge i_core_clk) begin
    // sole master; a new request is dropped while hold_acknowledge is high
    req_cnt <= (i_go_req && !i_hold_ack) ? 2'h3 : req_cnt - {1'b0, req_cnt != 2'h0};
    rel_cnt <= i_go_rel ? 2'h3 : rel_cnt - {1'b0, rel_cnt != 2'h0};
    rd_ff <= ~rd_ff;
  end
  // read data toggles so a stale value cannot pass
  assign o_cable_ad = rd_ff;
  assign o_cable_hs = '{req: req_cnt != 2'h0, grant: 1'b0, rel: rel_cnt != 2'h0};
endmodule
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // three sync flops, the filter flop, then two delay stages
  localparam int LAT = 4, PIPE = 6;
  logic clk = 1'b0, rst_n = 1'b0, emu = 1'b1, minc = 1'b0, runsel = 1'b0, prst = 1'b0, crst = 1'b0;
  logic reinit = 1'b0, uhold = 1'b0, cpurst = 1'b0, brk = 1'b0, nmi = 1'b0, amap = 1'b0, cstart = 1'b0;
  logic rdc = 1'b0, intc = 1'b0, go_req = 1'b0, go_rel = 1'b0, seen_dir = 1'b0, seen_mio = 1'b0;
  logic hs_req, hs_rel, nmi_tk, brk_tk, trc, oe_n, dirx, mio;
  logic [1:0] mon = 2'h0;
  logic [15:0] cpu_ad = 16'h0, emu_rd = 16'h0, cab_ad, rdata, ad_out;
  logic [31:0] r;
  epb_pkg::epb_hs_s cpu_hs = '0, cab_hs, ocab;
  epb_pkg::epb_cyc_s cyc = '0;
  epb_pkg::epb_hs_s hist[$];
  int miscompares = 0, n_tests = 0, n, seed = 32'h22d6;
  always #4 clk = ~clk;
  epb_probe_bus #(.LAT_CYC(LAT)) uut (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_emulating(emu), .i_min_config(minc), .i_coproc_run_select(runsel),
    .i_probe_reset(prst), .i_coproc_reset(crst), .i_unit_reinit(reinit), .i_unit_hold(uhold), .i_cpu_reset(cpurst),
    .i_break_event(brk), .i_nmi_pin(nmi), .i_cable_hs(cab_hs), .i_cpu_hs(cpu_hs), .i_all_mapped(amap),
    .i_cpu_ad(cpu_ad), .i_cable_ad(cab_ad), .i_emu_rdata(emu_rd), .i_cyc_start(cstart), .i_cyc(cyc),
    .i_rd_cmd(rdc), .i_intack_cmd(intc), .o_cpu_hs_req(hs_req), .o_cpu_hs_rel(hs_rel), .o_cable_hs(ocab),
    .o_nmi_take(nmi_tk), .o_break_take(brk_tk), .o_trace_coproc(trc), .o_cpu_rdata(rdata), .o_ad_out(ad_out),
    .o_ad_oe_n(oe_n), .o_dir_xmit(dirx), .o_mem_io_sel(mio));
  epb_partner far_end (.i_core_clk(clk), .i_go_req(go_req), .i_go_rel(go_rel), .i_hold_ack(ocab.grant),
    .o_cable_hs(cab_hs), .o_cable_ad(cab_ad));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always @(posedge clk) begin
    if (mon == 2'h1 && dirx === 1'b1) seen_dir <= 1'b1;
    if (mon == 2'h2 && mio === 1'b1) seen_mio <= 1'b1;
  end
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  task automatic close_out;
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return hs_req;
      1: return nmi_tk;
      2: return brk_tk;
      default: return hs_rel;
    endcase
  endfunction
  // edges until the chosen output is seen high, capped at lim
  task automatic watch(input int w, input int lim, output int cnt);
    cnt = 0;
    #1;
    while (sel(w) !== 1'b1 && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask
  task automatic hs_pulse(input logic rel);
    @(posedge clk);
    if (rel) go_rel <= 1'b1;
    else go_req <= 1'b1;
    @(posedge clk);
    go_req <= 1'b0;
    go_rel <= 1'b0;
  endtask
  task automatic strobe(input int w);
    repeat (2) begin
      @(posedge clk);
      case (w)
        0: crst <= ~crst;
        1: prst <= ~prst;
        2: reinit <= ~reinit;
        3: uhold <= ~uhold;
        default: brk <= ~brk;
      endcase
    end
  endtask
  task automatic nmi_pin;
    @(posedge clk);
    nmi <= 1'b1;
    repeat (4) @(posedge clk);
    nmi <= 1'b0;
  endtask
  task automatic bus(input logic [4:0] c, input int w);
    @(posedge clk);
    cyc <= epb_pkg::epb_cyc_s'(c);
    rdc <= c[4];
    intc <= c[2];
    cstart <= 1'b1;
    @(posedge clk);
    cstart <= 1'b0;
    repeat (w) @(posedge clk);
    #1;
  endtask
  initial begin
    #100000;
    miscompares++;
    close_out;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    check(oe_n === 1'b1 && mio === 1'b1 && hs_req === 1'b0, "reset values");
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      minc <= m[0];
      hs_pulse(1'b0);
      watch(0, 20, n);
      check(n == PIPE, "req latency");
      check(trc === (m == 0), "coproc trace");
      hs_pulse(1'b1);
      watch(3, 20, n);
      check(n == PIPE, "rel latency");
      repeat (6) @(posedge clk);
    end
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      r = $random(seed);
      cpu_hs <= epb_pkg::epb_hs_s'(r[2:0]);
      hist.push_back(epb_pkg::epb_hs_s'(r[2:0]));
      #1;
      if (i >= 2) check(ocab === hist[i-2], "outbound delay");
    end
    @(posedge clk);
    cpu_hs <= '0;
    prst <= 1'b1;
    hs_pulse(1'b0);
    watch(0, 12, n);
    check(n == 12, "req in probe reset");
    prst <= 1'b0;
    emu <= 1'b0;
    hs_pulse(1'b0);
    watch(0, 30, n);
    check(n >= PIPE && n <= PIPE + LAT, "interrogation latency");
    repeat (6) @(posedge clk);
    runsel <= 1'b1;
    hs_pulse(1'b0);
    watch(0, 12, n);
    check(n == 12, "latched req leaked");
    @(posedge clk);
    emu <= 1'b1;
    watch(0, 12, n);
    check(n < 12, "latched req lost");
    repeat (8) @(posedge clk);
    emu <= 1'b0;
    hs_pulse(1'b0);
    repeat (8) @(posedge clk);
    strobe(0);
    strobe(1);
    @(posedge clk);
    emu <= 1'b1;
    watch(0, 12, n);
    check(n == 12, "discarded req honoured");
    for (int c = 4; c > 1; c--) begin
      @(posedge clk);
      emu <= 1'b0;
      nmi_pin;
      watch(1, 10, n);
      check(n == 10, "nmi in interrogation");
      if (c < 4) strobe(c);
      @(posedge clk);
      emu <= 1'b1;
      watch(1, 10, n);
      check((n < 10) === (c == 4), "nmi after resume");
    end
    strobe(4);
    watch(2, 10, n);
    check(n < 10, "break not taken");
    @(posedge clk);
    cpurst <= 1'b1;
    repeat (5) @(posedge clk);
    strobe(4);
    repeat (5) @(posedge clk);
    cpurst <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      repeat (5) @(posedge clk);
      if (k == 1) strobe(2);
      strobe(4);
      watch(2, 10, n);
      check((n < 10) === (k == 1), "break after reset");
    end
    @(posedge clk);
    r = $random(seed);
    emu_rd <= r[15:0];
    cpu_ad <= r[31:16];
    amap <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      bus(5'h10 >> k, 5);
      check(oe_n === (k != 1), "bus float in T4");
      if (k == 1) check(ad_out === cpu_ad, "write data");
    end
    @(posedge clk);
    intc <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(oe_n === 1'b0, "float ends with acknowledge");
    check(rdata === emu_rd, "mapped read data");
    bus(5'h11, 2);
    mon = 2'h1;
    bus(5'h11, 2);
    bus(5'h12, 2);
    mon = 2'h2;
    bus(5'h12, 5);
    check(seen_dir === 1'b1, "direction pulse");
    check(seen_mio === 1'b1, "io select pulse");
    close_out;
  end
endmodule
`default_nettype wire

/* core/epb_probe_bus.sv */
// How it works
// - handshake pulses, and hold/hold_acknowledge, are delayed two clocks during emulation
// - coprocessor request/release reaches internal processor six clocks after the cable (three sync flops, filter flop, two delay stages)
// - coprocessor_run_select 1 allows coprocessor in emulation only
// - coprocessor running in interrogation sees up to 1 us extra latency
// - coprocessor requests ignored while probe is in reset state
// - run_select 1 in interrogation latches requests; cleared by coproc then probe reset
// - minimum configuration does not trace coprocessor bus activity
// - break during processor reset high is lost; only reinit clears that state
// - nmi in interrogation is latched, taken at emulation; reinit or hold clears
// - all-mapped mode drives cable outputs but ignores prototype read data
// - minimum configuration pulses direction high between program reads
// - back-to-back io cycles pulse memory_or_io_select high in T1 of the second cycle (set at the T4 edge, registered)
// - bus floats in T4 of read while read command, of interrupt acknowledge while asserted
// - write cycles keep the bus driven through T4
`timescale 1ns/1ns
`default_nettype none
`include "epb_regs.svh"
module epb_probe_bus #(
  parameter int LAT_CYC = `EPB_INTERRO_LAT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_emulating,
  input wire logic i_min_config,
  input wire logic i_coproc_run_select,
  input wire logic i_probe_reset,
  input wire logic i_coproc_reset,
  input wire logic i_unit_reinit,
  input wire logic i_unit_hold,
  input wire logic i_cpu_reset,
  input wire logic i_break_event,
  input wire logic i_nmi_pin,
  input wire epb_pkg::epb_hs_s i_cable_hs,
  input wire epb_pkg::epb_hs_s i_cpu_hs,
  input wire logic i_all_mapped,
  input wire logic [15:0] i_cpu_ad,
  input wire logic [15:0] i_cable_ad,
  input wire logic [15:0] i_emu_rdata,
  input wire logic i_cyc_start,
  input wire epb_pkg::epb_cyc_s i_cyc,
  input wire logic i_rd_cmd,
  input wire logic i_intack_cmd,
  output logic o_cpu_hs_req,
  output logic o_cpu_hs_rel,
  output epb_pkg::epb_hs_s o_cable_hs,
  output logic o_nmi_take,
  output logic o_break_take,
  output logic o_trace_coproc,
  output logic [15:0] o_cpu_rdata,
  output logic [15:0] o_ad_out,
  output logic o_ad_oe_n,
  output logic o_dir_xmit,
  output logic o_mem_io_sel
);
  // ----------------------------------------
  // pin synchronisers (3 flops, last two must agree)
  // ----------------------------------------
  logic [2:0] s_req_ff, s_rel_ff, s_nmi_ff, s_rst_ff;
  logic [2:0] nxt_s_req, nxt_s_rel, nxt_s_nmi, nxt_s_rst;
  logic req_q_ff, rel_q_ff, nmi_q_ff, rst_q_ff;
  logic nxt_req_q, nxt_rel_q, nxt_nmi_q, nxt_rst_q;

  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[1] == s[2]) ? s[1] : prev;
  endfunction

  always_comb begin
    nxt_s_req = {s_req_ff[1:0], i_cable_hs.req};
    nxt_s_rel = {s_rel_ff[1:0], i_cable_hs.rel};
    nxt_s_nmi = {s_nmi_ff[1:0], i_nmi_pin};
    nxt_s_rst = {s_rst_ff[1:0], i_cpu_reset};
    nxt_req_q = filt(s_req_ff, req_q_ff);
    nxt_rel_q = filt(s_rel_ff, rel_q_ff);
    nxt_nmi_q = filt(s_nmi_ff, nmi_q_ff);
    nxt_rst_q = filt(s_rst_ff, rst_q_ff);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_req_ff <= 3'h0;
      s_rel_ff <= 3'h0;
      s_nmi_ff <= 3'h0;
      s_rst_ff <= 3'h0;
      req_q_ff <= 1'b0;
      rel_q_ff <= 1'b0;
      nmi_q_ff <= 1'b0;
      rst_q_ff <= 1'b0;
    end else begin
      s_req_ff <= nxt_s_req;
      s_rel_ff <= nxt_s_rel;
      s_nmi_ff <= nxt_s_nmi;
      s_rst_ff <= nxt_s_rst;
      req_q_ff <= nxt_req_q;
      rel_q_ff <= nxt_rel_q;
      nmi_q_ff <= nxt_nmi_q;
      rst_q_ff <= nxt_rst_q;
    end
  end

  // ----------------------------------------
  // coprocessor gating and pending latch
  // ----------------------------------------
  logic run_ok, pend_ff, nxt_pend, creset_seen_ff, nxt_creset_seen;
  logic [15:0] lat_ff, nxt_lat;
  logic in_req, in_rel;

  always_comb begin
    run_ok = i_emulating || (i_coproc_run_select != `EPB_RUNSEL_EMU_ONLY);
    nxt_pend = pend_ff;
    nxt_creset_seen = creset_seen_ff;
    nxt_lat = lat_ff;
    if (!run_ok && req_q_ff && !i_probe_reset)
      nxt_pend = 1'b1;
    else if (run_ok && pend_ff)
      nxt_pend = 1'b0;
    if (i_probe_reset && creset_seen_ff) begin
      nxt_pend = 1'b0;
      nxt_creset_seen = 1'b0;
    end
    // a new coprocessor reset wins over the clear
    if (i_coproc_reset)
      nxt_creset_seen = 1'b1;
    // interrogation running adds a latency wait; once started it runs out even if the pulse ends
    if (!i_emulating && run_ok && (req_q_ff || lat_ff != 16'h0) && lat_ff < LAT_CYC[15:0])
      nxt_lat = lat_ff + 16'h1;
    else if (i_emulating || !req_q_ff)
      nxt_lat = 16'h0;
    in_req = !i_probe_reset && run_ok &&
             (i_emulating ? (req_q_ff || pend_ff) : (lat_ff == LAT_CYC[15:0]));
    in_rel = !i_probe_reset && run_ok && rel_q_ff;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_ff <= 1'b0;
      creset_seen_ff <= 1'b0;
      lat_ff <= 16'h0;
    end else begin
      pend_ff <= nxt_pend;
      creset_seen_ff <= nxt_creset_seen;
      lat_ff <= nxt_lat;
    end
  end

  // ----------------------------------------
  // two-stage handshake delay
  // ----------------------------------------
  logic [1:0] d_req_ff, d_rel_ff, nxt_d_req, nxt_d_rel;
  epb_pkg::epb_hs_s d_out0_ff, d_out1_ff, nxt_d_out0;

  always_comb begin
    nxt_d_req = {d_req_ff[0], in_req};
    nxt_d_rel = {d_rel_ff[0], in_rel};
    nxt_d_out0 = i_cpu_hs;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      d_req_ff <= 2'h0;
      d_rel_ff <= 2'h0;
      d_out0_ff <= '0;
      d_out1_ff <= '0;
    end else begin
      d_req_ff <= nxt_d_req;
      d_rel_ff <= nxt_d_rel;
      d_out0_ff <= nxt_d_out0;
      d_out1_ff <= d_out0_ff;
    end
  end
  assign o_cpu_hs_req = d_req_ff[1];
  assign o_cpu_hs_rel = d_rel_ff[1];
  assign o_cable_hs = d_out1_ff;

  // ----------------------------------------
  // break loss and nmi latch
  // ----------------------------------------
  logic brk_lost_ff, nxt_brk_lost, nmi_pend_ff, nxt_nmi_pend, nmi_prev_ff;
  logic brk_take_ff, nxt_brk_take, nmi_take_ff, nxt_nmi_take;

  always_comb begin
    nxt_brk_lost = brk_lost_ff;
    if (i_break_event && rst_q_ff)
      nxt_brk_lost = 1'b1;
    else if (i_unit_reinit)
      nxt_brk_lost = 1'b0;
    nxt_brk_take = i_break_event && !rst_q_ff && !brk_lost_ff;
    nxt_nmi_pend = nmi_pend_ff;
    nxt_nmi_take = 1'b0;
    if (nmi_q_ff && !nmi_prev_ff && !i_emulating)
      nxt_nmi_pend = 1'b1;
    else if (i_unit_reinit || i_unit_hold)
      nxt_nmi_pend = 1'b0;
    else if (i_emulating && nmi_pend_ff) begin
      nxt_nmi_pend = 1'b0;
      nxt_nmi_take = 1'b1;
    end
    if (nmi_q_ff && !nmi_prev_ff && i_emulating)
      nxt_nmi_take = 1'b1;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      brk_lost_ff <= 1'b0;
      nmi_pend_ff <= 1'b0;
      nmi_prev_ff <= 1'b0;
      brk_take_ff <= 1'b0;
      nmi_take_ff <= 1'b0;
    end else begin
      brk_lost_ff <= nxt_brk_lost;
      nmi_pend_ff <= nxt_nmi_pend;
      nmi_prev_ff <= nmi_q_ff;
      brk_take_ff <= nxt_brk_take;
      nmi_take_ff <= nxt_nmi_take;
    end
  end
  assign o_break_take = brk_take_ff;
  assign o_nmi_take = nmi_take_ff;

  // ----------------------------------------
  // bus cycle timing and float
  // ----------------------------------------
  epb_pkg::epb_tstate_e ts_ff, nxt_ts;
  epb_pkg::epb_cyc_s cyc_ff, nxt_cyc;
  logic prev_io_ff, prev_prog_ff, nxt_prev_io, nxt_prev_prog;
  logic oe_n_ff, dir_ff, mio_ff, trc_ff, nxt_oe_n, nxt_dir, nxt_mio;
  logic [15:0] ad_ff, rd_ff, nxt_rd;

  always_comb begin
    nxt_ts = ts_ff;
    nxt_cyc = cyc_ff;
    nxt_prev_io = prev_io_ff;
    nxt_prev_prog = prev_prog_ff;
    case (ts_ff)
      epb_pkg::EPB_T1: nxt_ts = epb_pkg::EPB_T2;
      epb_pkg::EPB_T2: nxt_ts = epb_pkg::EPB_T3;
      epb_pkg::EPB_T3: nxt_ts = epb_pkg::EPB_T4;
      epb_pkg::EPB_T4: begin
        if (i_cyc_start) begin
          nxt_ts = epb_pkg::EPB_T1;
          nxt_cyc = i_cyc;
          nxt_prev_io = cyc_ff.is_io;
          nxt_prev_prog = cyc_ff.is_prog && cyc_ff.is_read;
        end
      end
      default: nxt_ts = epb_pkg::EPB_T4;
    endcase
    nxt_oe_n = 1'b0;
    if (ts_ff == epb_pkg::EPB_T4 && !cyc_ff.is_write &&
        ((cyc_ff.is_read && i_rd_cmd) || (cyc_ff.is_intack && i_intack_cmd)))
      nxt_oe_n = 1'b1;
    else if (ts_ff != epb_pkg::EPB_T1 && ts_ff != epb_pkg::EPB_T4 && !cyc_ff.is_write &&
             (cyc_ff.is_read || cyc_ff.is_intack))
      nxt_oe_n = 1'b1;
    nxt_dir = cyc_ff.is_write;
    if (i_min_config && i_cyc_start && ts_ff == epb_pkg::EPB_T4 && cyc_ff.is_prog && i_cyc.is_prog)
      nxt_dir = 1'b1;
    nxt_mio = !cyc_ff.is_io;
    if (ts_ff == epb_pkg::EPB_T4 && cyc_ff.is_io && i_cyc_start && i_cyc.is_io)
      nxt_mio = 1'b1;
    nxt_rd = i_all_mapped ? i_emu_rdata : i_cable_ad;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ts_ff <= epb_pkg::EPB_T4;
      cyc_ff <= '0;
      prev_io_ff <= 1'b0;
      prev_prog_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      dir_ff <= 1'b0;
      mio_ff <= 1'b1;
      ad_ff <= 16'h0;
      rd_ff <= 16'h0;
      trc_ff <= 1'b0;
    end else begin
      ts_ff <= nxt_ts;
      cyc_ff <= nxt_cyc;
      prev_io_ff <= nxt_prev_io;
      prev_prog_ff <= nxt_prev_prog;
      oe_n_ff <= nxt_oe_n;
      dir_ff <= nxt_dir;
      mio_ff <= nxt_mio;
      ad_ff <= i_cpu_ad;
      rd_ff <= nxt_rd;
      trc_ff <= !i_min_config && (in_req || in_rel);
    end
  end
  assign o_ad_out = ad_ff;
  assign o_ad_oe_n = oe_n_ff;
  assign o_dir_xmit = dir_ff;
  assign o_mem_io_sel = mio_ff;
  assign o_cpu_rdata = rd_ff;
  assign o_trace_coproc = trc_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_OUT_DELAY: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    ##2 o_cable_hs == $past(i_cpu_hs, 2)) else $error("outbound handshake not delayed two clocks");
  AST_IN_DELAY: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    in_req |-> ##2 o_cpu_hs_req) else $error("inbound request not delayed two clocks");
  AST_RESET_IGNORE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_probe_reset |-> ##2 !o_cpu_hs_req) else $error("request passed during probe reset");
  AST_EMU_ONLY: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (!i_emulating && i_coproc_run_select) |-> !in_req) else $error("coprocessor ran in interrogation");
  AST_PEND: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (!run_ok && req_q_ff && !i_probe_reset) |=> pend_ff) else $error("pending request not latched");
  AST_NO_TRACE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_min_config |=> !o_trace_coproc) else $error("coprocessor traced in minimum config");
  AST_BRK_LOST: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_break_event && rst_q_ff) |=> ##1 !o_break_take) else $error("break taken during reset");
  AST_NMI_LATCH: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (nmi_q_ff && !nmi_prev_ff && !i_emulating) |=> nmi_pend_ff) else $error("nmi not latched");
  AST_WR_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (ts_ff == epb_pkg::EPB_T4 && cyc_ff.is_write) |=> !o_ad_oe_n) else $error("write bus floated");
endmodule
`default_nettype wire

/* pkg/epb_pkg.sv */
package epb_pkg;
  typedef enum logic [3:0] {
    EPB_T1 = 4'b0001,
    EPB_T2 = 4'b0010,
    EPB_T3 = 4'b0100,
    EPB_T4 = 4'b1000
  } epb_tstate_e;
  typedef struct packed {
    logic req;
    logic grant;
    logic rel;
  } epb_hs_s;
  typedef struct packed {
    logic is_read;
    logic is_write;
    logic is_intack;
    logic is_io;
    logic is_prog;
  } epb_cyc_s;
endpackage

/* pkg/epb_regs.svh */
`ifndef EPB_REGS_SVH
`define EPB_REGS_SVH
// handshake delay in clocks
`define EPB_HS_DELAY 2
// extra interrogation latency, ns, and its clock count at 125 MHz (8 ns)
`define EPB_INTERRO_LAT_NS 1000
`define EPB_CLK_PERIOD_NS 8
`define EPB_INTERRO_LAT_CYC (`EPB_INTERRO_LAT_NS / `EPB_CLK_PERIOD_NS)
// coprocessor_run_select value meaning emulation only
`define EPB_RUNSEL_EMU_ONLY 1'b1
`endif
